// file: rtl/chf_framer.sv
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module chf_framer (
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic [3:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic [31:0]            o_avs_readdata,
   output logic                   o_avs_waitrequest,
   input  wire logic              i_pkt_start,
   input  wire chf_pkg::chf_desc_s i_pkt_desc,
   output logic                   o_pkt_ready,
   input  wire logic [7:0]        i_pay_data,
   input  wire logic              i_pay_valid,
   input  wire logic              i_pay_last,
   output logic                   o_pay_ready,
   output logic [7:0]             o_out_data,
   output logic                   o_out_valid,
   output logic                   o_out_sop,
   output logic                   o_out_eop,
   output logic                   o_out_tcp,
   input  wire logic              i_out_ready
);

   chf_pkg::chf_state_e state_reg;
   chf_pkg::chf_desc_s  desc_reg;
   logic [4:0]          oct_reg;
   logic [15:0]         seq_reg;
   logic [15:0]         seq_pkt_reg;
   logic [31:0]         count_reg;
   logic                vsel_reg;
   logic                xport_reg;
   logic                xport_pkt_reg;
   logic                vsel_pkt_reg;
   logic                seq_clr_req;
   logic                ack_reg;
   logic                out_take;
   logic                pay_take;
   logic                pkt_take;
   logic [7:0]          hdr_octet;
   logic                pay_begun_reg;

   // A new byte enters the output stage when it is empty or being drained.
   assign out_take = !o_out_valid || i_out_ready;
   // The registered ready flags are only high inside their state, so taking on them
   // keeps the handshake exact: a held request is never taken twice.
   assign pkt_take = o_pkt_ready && i_pkt_start && out_take;
   assign pay_take = o_pay_ready && i_pay_valid && out_take;

   // Header octet for the current index.
   always_comb begin
      hdr_octet = chf_pkg::FILL_ZERO;
      case (oct_reg)
         5'h00: hdr_octet = {chf_pkg::HDR_VERSION_0, 1'b1, 1'b1,
                             desc_reg.at_serving, desc_reg.from_user, 1'b0};
         5'h01: hdr_octet = chf_pkg::MSG_TYPE_VALUE;
         5'h02: hdr_octet = desc_reg.payload_len[15:8];
         5'h03: hdr_octet = desc_reg.payload_len[7:0];
         5'h04: hdr_octet = seq_pkt_reg[15:8];
         5'h05: hdr_octet = seq_pkt_reg[7:0];
         5'h06: hdr_octet = chf_pkg::FILL_ZERO;
         5'h07: hdr_octet = chf_pkg::FILL_ZERO;
         5'h08: hdr_octet = chf_pkg::FILL_ONES;
         5'h09: hdr_octet = chf_pkg::FILL_ONES;
         5'h0A: hdr_octet = chf_pkg::FILL_ONES;
         5'h0B: hdr_octet = chf_pkg::FILL_ONES;
         5'h0C: hdr_octet = desc_reg.gateway_id[31:24];
         5'h0D: hdr_octet = desc_reg.gateway_id[23:16];
         5'h0E: hdr_octet = desc_reg.gateway_id[15:8];
         5'h0F: hdr_octet = desc_reg.gateway_id[7:0];
         5'h10: hdr_octet = desc_reg.billing_id[31:24];
         5'h11: hdr_octet = desc_reg.billing_id[23:16];
         5'h12: hdr_octet = desc_reg.billing_id[15:8];
         5'h13: hdr_octet = desc_reg.billing_id[7:0];
         default: hdr_octet = chf_pkg::FILL_ZERO;
      endcase
   end

   // Framing sequence.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg     <= chf_pkg::ST_IDLE;
         desc_reg      <= '0;
         oct_reg       <= '0;
         seq_pkt_reg   <= chf_pkg::SEQ_RESET;
         xport_pkt_reg <= chf_pkg::XPORT_UDP;
         vsel_pkt_reg  <= chf_pkg::VSEL_RESET;
      end else begin
         case (state_reg)
            chf_pkg::ST_IDLE: begin
               if (pkt_take) begin
                  desc_reg      <= i_pkt_desc;
                  seq_pkt_reg   <= seq_reg;
                  xport_pkt_reg <= xport_reg;
                  vsel_pkt_reg  <= vsel_reg;
                  oct_reg       <= '0;
                  // Version 1 skips the fixed header.
                  state_reg     <= (vsel_reg == chf_pkg::VSEL_V0) ?
                                   chf_pkg::ST_HDR : chf_pkg::ST_PAY;
               end
            end
            chf_pkg::ST_HDR: begin
               if (out_take) begin
                  if (oct_reg == chf_pkg::OCT_IDX_LAST) begin
                     state_reg <= chf_pkg::ST_PAY;
                  end else begin
                     oct_reg <= oct_reg + 5'h01;
                  end
               end
            end
            chf_pkg::ST_PAY: begin
               if (pay_take && i_pay_last) begin
                  state_reg <= chf_pkg::ST_IDLE;
               end
            end
            default: state_reg <= chf_pkg::ST_IDLE;
         endcase
      end
   end

   // Output byte stage; a downstream stall holds the byte, nothing is kept for replay.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_out_data  <= '0;
         o_out_valid <= 1'b0;
         o_out_sop   <= 1'b0;
         o_out_eop   <= 1'b0;
         o_out_tcp   <= chf_pkg::XPORT_UDP;
      end else if (out_take) begin
         o_out_valid <= 1'b0;
         o_out_sop   <= 1'b0;
         o_out_eop   <= 1'b0;
         if (state_reg == chf_pkg::ST_HDR) begin
            o_out_data  <= hdr_octet;
            o_out_valid <= 1'b1;
            o_out_sop   <= (oct_reg == 5'h00);
            o_out_tcp   <= xport_pkt_reg;
         end else if (pay_take) begin
            o_out_data  <= i_pay_data;
            o_out_valid <= 1'b1;
            o_out_sop   <= (vsel_pkt_reg == chf_pkg::VSEL_V1) && !pay_begun_reg;
            o_out_eop   <= i_pay_last;
            o_out_tcp   <= xport_pkt_reg;
         end
      end
   end

   // Marks that a version 1 payload has already begun, so only its first byte is sop.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pay_begun_reg <= 1'b0;
      end else if (pkt_take) begin
         pay_begun_reg <= 1'b0;
      end else if (pay_take) begin
         pay_begun_reg <= 1'b1;
      end
   end

   // Handshake readiness registered so the ports come from flops.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pkt_ready <= 1'b0;
         o_pay_ready <= 1'b0;
      end else begin
         o_pkt_ready <= (state_reg == chf_pkg::ST_IDLE) && !pkt_take;
         o_pay_ready <= (state_reg == chf_pkg::ST_PAY) && !(pay_take && i_pay_last);
      end
   end

   // Sequence counter; the clear request from software loses to a packet start in the same cycle.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         seq_reg   <= chf_pkg::SEQ_RESET;
         count_reg <= '0;
      end else begin
         if (pkt_take) begin
            seq_reg   <= seq_reg + chf_pkg::SEQ_STEP;
            count_reg <= count_reg + 32'h0000_0001;
         end else if (seq_clr_req) begin
            seq_reg <= chf_pkg::SEQ_RESET;
         end
      end
   end

   // Register bus: one-cycle wait, then the answer.
   assign seq_clr_req = i_avs_write && !ack_reg && (i_avs_address == chf_pkg::REG_CTRL_ADDR)
                        && i_avs_byteenable[0] && i_avs_writedata[chf_pkg::CTRL_SEQCLR_BIT];

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_reg           <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= '0;
         vsel_reg          <= chf_pkg::VSEL_RESET;
         xport_reg         <= chf_pkg::XPORT_UDP;
      end else begin
         ack_reg           <= (i_avs_read || i_avs_write) && !ack_reg;
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_reg);
         if (i_avs_write && !ack_reg && i_avs_address == chf_pkg::REG_CTRL_ADDR
             && i_avs_byteenable[0]) begin
            vsel_reg  <= i_avs_writedata[chf_pkg::CTRL_VSEL_BIT];
            // Transport choice; no retransmit logic exists.
            xport_reg <= i_avs_writedata[chf_pkg::CTRL_XPORT_BIT];
         end
         if (i_avs_read && !ack_reg) begin
            case (i_avs_address)
               chf_pkg::REG_CTRL_ADDR:  o_avs_readdata <= {30'h0, xport_reg, vsel_reg};
               chf_pkg::REG_STAT_ADDR:  o_avs_readdata <= {28'h0, vsel_pkt_reg,
                                                           o_out_valid, state_reg};
               chf_pkg::REG_SEQ_ADDR:   o_avs_readdata <= {16'h0, seq_reg};
               chf_pkg::REG_COUNT_ADDR: o_avs_readdata <= count_reg;
               default:                 o_avs_readdata <= chf_pkg::UNMAPPED_DATA;
            endcase
         end
      end
   end

endmodule // chf_framer
`default_nettype wire

// file: rtl/chf_pkg.sv
package chf_pkg;

   // Header geometry and fixed field values.
   localparam int unsigned HDR_OCTETS      = 20;
   localparam logic [2:0]  HDR_VERSION_0   = 3'h0;
   localparam logic [7:0]  MSG_TYPE_VALUE  = 8'hFF;
   localparam logic [7:0]  FILL_ZERO       = 8'h00;
   localparam logic [7:0]  FILL_ONES       = 8'hFF;
   localparam logic [15:0] SEQ_RESET       = 16'h0000;
   localparam logic [15:0] SEQ_STEP        = 16'h0001;
   localparam logic [4:0]  OCT_IDX_LAST    = 5'h13;

   // Transport selector values.
   localparam logic        XPORT_UDP       = 1'b0;
   localparam logic        XPORT_TCP       = 1'b1;

   // Header format version select; version 1 is the default after reset.
   localparam logic        VSEL_V0         = 1'b0;
   localparam logic        VSEL_V1         = 1'b1;
   localparam logic        VSEL_RESET      = VSEL_V1;

   // Avalon-MM register map, byte addresses.
   localparam logic [3:0]  REG_CTRL_ADDR   = 4'h0;
   localparam logic [3:0]  REG_STAT_ADDR   = 4'h4;
   localparam logic [3:0]  REG_SEQ_ADDR    = 4'h8;
   localparam logic [3:0]  REG_COUNT_ADDR  = 4'hC;
   localparam int unsigned CTRL_VSEL_BIT   = 0;
   localparam int unsigned CTRL_XPORT_BIT  = 1;
   localparam int unsigned CTRL_SEQCLR_BIT = 2;
   localparam logic [31:0] UNMAPPED_DATA   = 32'hDEAD_BEEF;

   // Per-packet descriptor given by the controller with each payload.
   typedef struct packed {
      logic [15:0] payload_len;
      logic [31:0] gateway_id;
      logic [31:0] billing_id;
      logic        from_user;
      logic        at_serving;
   } chf_desc_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HDR,
      ST_PAY
   } chf_state_e;

endpackage

// file: verif/chf_framer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module chf_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_rst,
   input wire logic [3:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic [7:0]  o_out_data,
   input wire logic        o_out_valid,
   input wire logic        o_out_sop,
   input wire logic        o_out_eop,
   input wire logic        o_out_tcp,
   input wire logic        i_out_ready
);
   logic       vsel_reg, tcp_reg, known_reg, v0_reg, in_pkt_reg;
   logic [4:0] idx_reg;
   wire        take = o_out_valid && i_out_ready;
   wire        ctl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0;
   wire        v0 = o_out_sop ? !vsel_reg : v0_reg;
   wire  [5:0] oct = o_out_sop ? 6'h01 : {1'h0, idx_reg} + 6'h01;
   // Shadow of the control bits; packets only start after a write has landed.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         vsel_reg <= 1'h1;
         tcp_reg <= 1'h0;
         known_reg <= 1'h0;
      end else if (ctl_wr) begin
         vsel_reg <= i_avs_writedata[0];
         tcp_reg <= i_avs_writedata[1];
         known_reg <= 1'h1;
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         idx_reg <= 5'h00;
         v0_reg <= 1'h0;
         in_pkt_reg <= 1'h0;
      end else if (take) begin
         idx_reg <= o_out_sop ? 5'h01 : idx_reg + {4'h0, idx_reg != 5'h1F};
         v0_reg <= v0;
         in_pkt_reg <= !o_out_eop;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus request not answered next cycle");
   bus_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   unmapped_read_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[1:0] != 2'h0
      |-> o_avs_readdata == 32'hDEAD_BEEF) else $error("unmapped read data wrong");
   version_octet_a: assert property (o_out_valid && o_out_sop && !vsel_reg
      |-> o_out_data[7:3] == 5'h03 && o_out_data[0] == 1'h0) else $error("first octet wrong");
   msg_type_a: assert property (o_out_valid && v0 && oct == 6'h02 |-> o_out_data == 8'hFF)
      else $error("message type octet wrong");
   filler_a: assert property (o_out_valid && v0 && oct > 6'h06 && oct < 6'h0D
      |-> o_out_data == (oct < 6'h09 ? 8'h00 : 8'hFF)) else $error("filler octet wrong");
   hold_out_a: assert property (o_out_valid && !i_out_ready
      |=> o_out_valid && $stable(o_out_data) && $stable(o_out_eop)) else $error("output byte dropped");
   one_payload_a: assert property (o_out_valid && o_out_sop |-> !in_pkt_reg)
      else $error("new frame before end of previous");
   transport_a: assert property (o_out_valid && known_reg |-> o_out_tcp == tcp_reg)
      else $error("transport select wrong");
endmodule // chf_chk
bind chf_framer chf_chk chk (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
   .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_out_data, .o_out_valid,
   .o_out_sop, .o_out_eop, .o_out_tcp, .i_out_ready);
`default_nettype wire

// file: verif/chf_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
module chf_framer_test;
   logic               clk = 1'h0;
   logic               rst = 1'h1;
   logic               rd = 1'h0, wr = 1'h0, start = 1'h0, pv = 1'h0, pl = 1'h0, stall = 1'h0;
   logic [3:0]         addr = 4'h0;
   logic [31:0]        wdata = 32'h0, q, rdata;
   logic [7:0]         pd = 8'h00, od;
   logic               wreq, prdy, yrdy, ov, osop, oeop, otcp, ordy;
   chf_pkg::chf_desc_s desc = '0, d;
   int                 miscompares = 0, comparisons = 0, cyc = 0;
   logic [10:0]        exq[$];
   always #5 clk = ~clk;
   chf_framer uut (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_pkt_start(start), .i_pkt_desc(desc), .o_pkt_ready(prdy),
      .i_pay_data(pd), .i_pay_valid(pv), .i_pay_last(pl), .o_pay_ready(yrdy), .o_out_data(od),
      .o_out_valid(ov), .o_out_sop(osop), .o_out_eop(oeop), .o_out_tcp(otcp), .i_out_ready(ordy));
   chf_sink sink (.i_sys_clk(clk), .i_rst(rst), .i_data(od), .i_valid(ov), .i_sop(osop),
      .i_eop(oeop), .i_tcp(otcp), .i_stall(stall), .o_ready(ordy));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] dat, output logic [31:0] r);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= dat;
      do @(posedge clk); while (wreq !== 1'h0);
      r = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task automatic send(input chf_pkg::chf_desc_s dd, input int n, input logic v0,
                       input logic [15:0] seq, input logic tcp);
      logic [159:0] hv;
      int           m, e;
      hv = {3'h0, 2'h3, dd.at_serving, dd.from_user, 1'h0, 8'hFF, dd.payload_len, seq,
            16'h0000, 32'hFFFF_FFFF, dd.gateway_id, dd.billing_id};
      m = n + (v0 ? 20 : 0);
      for (int k = 0; k < m; k++)
         exq.push_back({tcp, k == 0, k == m - 1, (v0 && k < 20) ? hv[159 - 8 * k -: 8] : 8'hA0 + 8'(k - m + n)});
      e = sink.eops;
      @(posedge clk);
      start <= 1'h1;
      desc <= dd;
      do @(posedge clk); while (!(prdy && (!ov || ordy)));
      start <= 1'h0;
      for (int k = 0; k < n; k++) begin
         pv <= 1'h1;
         pd <= 8'hA0 + 8'(k);
         pl <= k == n - 1;
         do @(posedge clk); while (!(yrdy && (!ov || ordy)));
      end
      pv <= 1'h0;
      while (sink.eops == e) @(posedge clk);
      check(sink.got_q.size(), exq.size());
      foreach (exq[k]) check(sink.got_q[k], exq[k]);
      exq.delete();
      sink.got_q.delete();
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      bus(1'h0, 4'h0, 32'h0, q);
      check(q & 32'h1, 32'h1);
      bus(1'h0, 4'h2, 32'h0, q);
      check(q, 32'hDEAD_BEEF);
      bus(1'h1, 4'h6, 32'h0, q);
      bus(1'h0, 4'h0, 32'h0, q);
      check(q & 32'h1, 32'h1);
      $display("Test registers done");
      d = '0;
      d.payload_len = 16'h0003;
      bus(1'h1, 4'h0, 32'h3, q);
      send(d, 3, 1'h0, 16'h0, 1'h1);
      $display("Test default format done");
      stall <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         d.from_user = i[0];
         d.at_serving = i[1];
         d.payload_len = 16'(i + 1);
         d.gateway_id = 32'h1234_5678;
         d.billing_id = 32'h9ABC_DE00 + 32'(i);
         bus(1'h1, 4'h0, {29'h0, i == 0, i[0] ^ i[1], 1'h0}, q);
         send(d, i + 1, 1'h1, 16'(i), i[0] ^ i[1]);
      end
      $display("Test version 0 framing done");
      bus(1'h0, 4'hC, 32'h0, q);
      check(q, 32'h5);
      give_verdict();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
endmodule // chf_framer_test
`default_nettype wire

// file: verif/chf_sink.sv
`timescale 1ns/1ps
`default_nettype none
module chf_sink (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_data,
   input  wire logic       i_valid,
   input  wire logic       i_sop,
   input  wire logic       i_eop,
   input  wire logic       i_tcp,
   input  wire logic       i_stall,
   output logic            o_ready
);
   logic [1:0]  cnt_reg;
   logic [10:0] got_q[$];
   int          eops = 0;
   // Stalls one cycle in four when asked, so held output bytes get exercised.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 2'h0;
         o_ready <= 1'h0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         o_ready <= !(i_stall && cnt_reg == 2'h2);
      end
   end
   // No continuity of sequence numbers is assumed here.
   always @(posedge i_sys_clk) begin
      if (!i_rst && i_valid && o_ready) begin
         got_q.push_back({i_tcp, i_sop, i_eop, i_data});
         if (i_eop) eops++;
      end
   end
endmodule // chf_sink
`default_nettype wire
